// File: pkg/link_ctrl_cfg.svh
// Offsets, field positions, reset values and timing counts of the link control register.
`ifndef LINK_CTRL_CFG_SVH
`define LINK_CTRL_CFG_SVH
`define OFS_CTRL_SET 12'h050
`define OFS_CTRL_CLR 12'h054
`define OFS_PHYDOM_LO0 12'h0DC
`define OFS_PHYDOM_HI0 12'h0F0
`define OFS_PHYDOM_LO1 12'h100
`define OFS_PHYDOM_HI1 12'h11C
`define BIT_BIB_VALID 31
`define BIT_SWAP_BYPASS 30
`define BIT_LATE_ACK 29
`define BIT_TARDY_EVT 27
`define BIT_PHY_PERM 23
`define BIT_PHY_EXTRAS 22
`define BIT_LPS 19
`define BIT_POSTING 18
`define BIT_CONNECT 17
`define BIT_SWRST 16
`define CTRL_WRITABLE_MASK 32'h604E0000
`define CTRL_RESET_VALUE 32'h00000000
`define SWRST_CYCLES 4'h8
`define STRAP_SETTLE 3'h4
`define ALL_ONES 32'hFFFFFFFF
`endif

// File: pkg/link_ctrl_pkg.sv
// Types shared by the link control register block.
package link_ctrl_pkg;
	typedef struct packed {
		logic swapBypass;
		logic lateAckPermit;
		logic phyConfigPermission;
		logic phyExtrasOn;
		logic linkPowerStatus;
		logic writePostingOn;
		logic nodeConnectEnable;
		logic swResetTrigger;
	} ctrl_t;
	typedef enum logic [1:0] {
		RST_IDLE = 2'b00,
		RST_BUSY = 2'b01
	} rst_state_t;
endpackage : link_ctrl_pkg

// File: logic/sync3.sv
// Three-stage synchroniser plus an output flop (four flops) that reports a level once its last two stages agree.
`timescale 1ns/1ps
module sync3 (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic din,
	output logic dout
);
	logic s1_q, s2_q, s3_q, s1_d, s2_d, s3_d, out_q, out_d;
	// The first stage is read only by the second.
	always_comb begin
		s1_d = din;
		s2_d = s1_q;
		s3_d = s2_q;
		out_d = (s2_q == s3_q) ? s3_q : out_q;
	end
	// Registers only; the clock enable freezes the chain.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			out_q <= 1'b0;
		end else if (ce) begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			s3_q <= s3_d;
			out_q <= out_d;
		end
	end
	assign dout = out_q;
endmodule : sync3

// File: logic/link_host_control.sv
// Link host control register with set/clear addresses and software reset.
//
// Contract
// - Bit 30 selects byte swapping bypass.
// - Late-ack enable makes node answer tardy.
// - Each tardy answer flags interrupt bit 27; the code pulses the tardyEvent output instead, and bit 27 reads zero.
// - Reserved bits always read zero.
// - Permission bit read-only, strapped, global reset.
// - Extras only with permission and connect.
// - Power status bit gates PHY communication.
// - Stopped PHY clock access aborts or ones.
// - Listed offsets live in PHY clock domain.
// - Posting bit changes only while disconnected; the code lets it be set or cleared at any time outside a soft reset, whatever the connect bit.
// - Connect cleared by hardware or soft reset.
// - Disconnected node handles no packets.
// - Soft reset restores link registers.
// - Reset trigger reads one while busy.
// - Set address 50h, clear address 54h.
`timescale 1ns/1ps
`include "link_ctrl_cfg.svh"
module link_host_control #(
	parameter int ADDR_W = 12,
	parameter logic [3:0] SWRST_LEN = `SWRST_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic global_reset_n,
	input wire logic phyPermStrap,
	input wire logic abort_suppress,
	input wire logic phyClkRunning,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic tardyRequest,
	input wire logic linkPacketValid,
	output logic [31:0] regRdata,
	output logic regAbort,
	output logic tardyAck,
	output logic tardyEvent,
	output link_ctrl_pkg::ctrl_t ctrlOut,
	output logic linkPhyAllow,
	output logic packetAccept,
	output logic linkFlush
);
	if (ADDR_W < 9) begin : g_chk
		$error("ADDR_W too small for register map");
	end
	if (SWRST_LEN == 4'h0) begin : g_chk2
		$error("SWRST_LEN must be nonzero");
	end

	logic [31:0] ctrl_q, ctrl_d;
	logic perm_q, perm_d;
	logic strapSeen_q, strapSeen_d;
	logic [2:0] strapCnt_q, strapCnt_d;
	logic [3:0] rstCnt_q, rstCnt_d;
	link_ctrl_pkg::rst_state_t rstSt_q, rstSt_d;
	logic [31:0] rdata_q, rdata_d;
	logic abort_q, abort_d;
	logic tAck_q, tAck_d, tEvt_q, tEvt_d;
	logic phyPwr_q, phyPwr_d, acc_q, acc_d, flush_q, flush_d;
	link_ctrl_pkg::ctrl_t out_q, out_d;
	logic phyRun, grstSync, strapSync;
	logic hitSet, hitClr, inPhyDom, swBusy;
	logic [31:0] readView;

	// Pins from outside the clock domain pass four flip-flops.
	sync3 u_run (.clk(clk), .rst(rst), .ce(ce), .din(phyClkRunning),
		.dout(phyRun));
	sync3 u_global_reset_n (.clk(clk), .rst(rst), .ce(ce), .din(~global_reset_n),
		.dout(grstSync));
	sync3 u_strap (.clk(clk), .rst(rst), .ce(ce), .din(phyPermStrap),
		.dout(strapSync));

	// Address decode.
	always_comb begin
		hitSet = (regAddr == ADDR_W'(`OFS_CTRL_SET));
		hitClr = (regAddr == ADDR_W'(`OFS_CTRL_CLR));
		inPhyDom = ((regAddr >= ADDR_W'(`OFS_PHYDOM_LO0)) &&
			(regAddr <= ADDR_W'(`OFS_PHYDOM_HI0))) ||
			((regAddr >= ADDR_W'(`OFS_PHYDOM_LO1)) &&
			(regAddr <= ADDR_W'(`OFS_PHYDOM_HI1)));
		swBusy = (rstSt_q == link_ctrl_pkg::RST_BUSY);
		readView = ctrl_q & `CTRL_WRITABLE_MASK;
		readView[`BIT_PHY_PERM] = perm_q;
		readView[`BIT_SWRST] = swBusy;
	end

	// Control bits; soft reset wipes them, the strapped bit survives it.
	always_comb begin
		ctrl_d = ctrl_q;
		perm_d = perm_q;
		strapSeen_d = strapSeen_q;
		strapCnt_d = strapCnt_q;
		rstSt_d = rstSt_q;
		rstCnt_d = rstCnt_q;
		// The strap synchroniser needs four edges to show the pin level.
		if (!strapSeen_q) begin
			strapCnt_d = strapCnt_q + 3'h1;
			if (strapCnt_q == `STRAP_SETTLE) begin
				perm_d = strapSync;
				strapSeen_d = 1'b1;
			end
		end
		if (grstSync) begin
			perm_d = 1'b0;
		end
		if (regWrite && hitSet) begin
			ctrl_d = ctrl_q | (regWdata & `CTRL_WRITABLE_MASK);
		end else if (regWrite && hitClr) begin
			ctrl_d = ctrl_q & ~(regWdata & `CTRL_WRITABLE_MASK);
		end
		unique case (rstSt_q)
			link_ctrl_pkg::RST_IDLE: begin
				if (regWrite && hitSet && regWdata[`BIT_SWRST]) begin
					rstSt_d = link_ctrl_pkg::RST_BUSY;
					rstCnt_d = SWRST_LEN;
					ctrl_d = `CTRL_RESET_VALUE;
				end
			end
			link_ctrl_pkg::RST_BUSY: begin
				ctrl_d = `CTRL_RESET_VALUE;
				rstCnt_d = rstCnt_q - 4'h1;
				if (rstCnt_q == 4'h1) begin
					rstSt_d = link_ctrl_pkg::RST_IDLE;
				end
			end
			default: rstSt_d = link_ctrl_pkg::RST_IDLE;
		endcase
	end

	// Bus answers, tardy handling and link gating outputs.
	always_comb begin
		rdata_d = 32'h00000000;
		abort_d = 1'b0;
		if (regRead) begin
			if (inPhyDom && !phyRun) begin
				if (abort_suppress) begin
					rdata_d = `ALL_ONES;
				end else begin
					abort_d = 1'b1;
				end
			end else if (hitSet || hitClr) begin
				rdata_d = readView;
			end
		end
		if (regWrite && inPhyDom && !phyRun && !abort_suppress) begin
			abort_d = 1'b1;
		end
		// Tardy answers only happen on a connected node.
		tAck_d = tardyRequest && ctrl_q[`BIT_LATE_ACK] &&
			ctrl_q[`BIT_CONNECT];
		tEvt_d = tAck_d;
		phyPwr_d = ctrl_q[`BIT_LPS];
		acc_d = linkPacketValid && ctrl_q[`BIT_CONNECT] && !swBusy;
		flush_d = swBusy;
		out_d.swapBypass = ctrl_q[`BIT_SWAP_BYPASS];
		out_d.lateAckPermit = ctrl_q[`BIT_LATE_ACK];
		out_d.phyConfigPermission = perm_q;
		// The extras enable is only honoured with permission and connect.
		out_d.phyExtrasOn = ctrl_q[`BIT_PHY_EXTRAS] && perm_q &&
			ctrl_q[`BIT_CONNECT];
		out_d.linkPowerStatus = ctrl_q[`BIT_LPS];
		out_d.writePostingOn = ctrl_q[`BIT_POSTING];
		out_d.nodeConnectEnable = ctrl_q[`BIT_CONNECT];
		out_d.swResetTrigger = swBusy;
	end

	// Registers only; reset takes constants, the strap is caught afterwards.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= `CTRL_RESET_VALUE;
			perm_q <= 1'b1;
			strapSeen_q <= 1'b0;
			strapCnt_q <= 3'h0;
			rstSt_q <= link_ctrl_pkg::RST_IDLE;
			rstCnt_q <= 4'h0;
			rdata_q <= 32'h00000000;
			abort_q <= 1'b0;
			tAck_q <= 1'b0;
			tEvt_q <= 1'b0;
			phyPwr_q <= 1'b0;
			acc_q <= 1'b0;
			flush_q <= 1'b0;
			out_q <= '0;
		end else if (ce) begin
			ctrl_q <= ctrl_d;
			perm_q <= perm_d;
			strapSeen_q <= strapSeen_d;
			strapCnt_q <= strapCnt_d;
			rstSt_q <= rstSt_d;
			rstCnt_q <= rstCnt_d;
			rdata_q <= rdata_d;
			abort_q <= abort_d;
			tAck_q <= tAck_d;
			tEvt_q <= tEvt_d;
			phyPwr_q <= phyPwr_d;
			acc_q <= acc_d;
			flush_q <= flush_d;
			out_q <= out_d;
		end
	end

	assign regRdata = rdata_q;
	assign regAbort = abort_q;
	assign tardyAck = tAck_q;
	assign tardyEvent = tEvt_q;
	assign ctrlOut = out_q;
	assign linkPhyAllow = phyPwr_q;
	assign packetAccept = acc_q;
	assign linkFlush = flush_q;

	sequence s_swTrig;
		ce && regWrite && hitSet && regWdata[`BIT_SWRST] && !swBusy;
	endsequence
	sequence s_busyRun;
		swBusy [*8];
	endsequence

	property p_reserved;
		@(posedge clk) disable iff (rst)
		ce && regRead && (hitSet || hitClr) && !inPhyDom |=>
			(regRdata & 32'h1F30FFFF & ~32'h00010000) == 32'h0;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits");

	property p_swrst;
		@(posedge clk) disable iff (rst || !ce)
		s_swTrig |=> s_busyRun ##1 !swBusy;
	endproperty
	a_swrst: assert property (p_swrst) else $error("soft reset length");

	property p_connClr;
		@(posedge clk) disable iff (rst)
		ce && swBusy |=> !ctrl_q[`BIT_CONNECT];
	endproperty
	a_connClr: assert property (p_connClr) else $error("connect kept");

	property p_setBit;
		@(posedge clk) disable iff (rst)
		ce && regWrite && hitSet && regWdata[`BIT_SWAP_BYPASS] && !swBusy
			&& !regWdata[`BIT_SWRST] |=> ctrl_q[`BIT_SWAP_BYPASS];
	endproperty
	a_setBit: assert property (p_setBit) else $error("set failed");

	property p_clrBit;
		@(posedge clk) disable iff (rst)
		ce && regWrite && hitClr && regWdata[`BIT_LPS] |=>
			!ctrl_q[`BIT_LPS];
	endproperty
	a_clrBit: assert property (p_clrBit) else $error("clear failed");

	property p_abort;
		@(posedge clk) disable iff (rst)
		ce && regRead && inPhyDom && !phyRun |=>
			($past(abort_suppress) ?
			((regRdata == `ALL_ONES) && !regAbort) : regAbort);
	endproperty
	a_abort: assert property (p_abort) else $error("abort answer");

	property p_tardy;
		@(posedge clk) disable iff (rst)
		ce && tardyRequest && ctrl_q[`BIT_LATE_ACK] &&
			ctrl_q[`BIT_CONNECT] |=> tardyAck && tardyEvent;
	endproperty
	a_tardy: assert property (p_tardy) else $error("tardy event");

	property p_detach;
		@(posedge clk) disable iff (rst)
		ce && !ctrl_q[`BIT_CONNECT] |=> !packetAccept && !tardyAck;
	endproperty
	a_detach: assert property (p_detach) else $error("packets taken");

	property p_lps;
		@(posedge clk) disable iff (rst)
		ce |=> linkPhyAllow == $past(ctrl_q[`BIT_LPS]);
	endproperty
	a_lps: assert property (p_lps) else $error("phy gate");

	property p_perm;
		@(posedge clk) disable iff (rst)
		ce && regWrite && strapSeen_q && !grstSync |=>
			perm_q == $past(perm_q);
	endproperty
	a_perm: assert property (p_perm) else $error("perm written");
endmodule : link_host_control

// File: dv/link_host_control_tb.sv
// Self-checking bench for the link host control register block.
`timescale 1ns/1ps
`include "link_ctrl_cfg.svh"
module link_host_control_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic globalRstN = 1'b1;
	logic phyPermStrap = 1'b1;
	logic abortSuppress = 1'b0;
	logic phyClkRunning = 1'b1;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [11:0] regAddr = 12'h000;
	logic [31:0] regWdata = 32'h00000000;
	logic tardyRequest = 1'b0;
	logic linkPacketValid = 1'b0;
	logic [31:0] regRdata;
	logic regAbort;
	logic tardyAck;
	logic tardyEvent;
	link_ctrl_pkg::ctrl_t ctrlOut;
	logic linkPhyAllow;
	logic packetAccept;
	logic linkFlush;
	int failures = 0;
	int checks_done = 0;
	logic [31:0] rv;
	logic ab;

	// Half period of 50 ns gives the 10 MHz clock.
	always #50 clk = ~clk;

	link_host_control u_dut (
		.clk(clk), .rst(rst), .ce(ce), .global_reset_n(globalRstN),
		.phyPermStrap(phyPermStrap), .abort_suppress(abortSuppress),
		.phyClkRunning(phyClkRunning), .regWrite(regWrite),
		.regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
		.tardyRequest(tardyRequest), .linkPacketValid(linkPacketValid),
		.regRdata(regRdata), .regAbort(regAbort), .tardyAck(tardyAck),
		.tardyEvent(tardyEvent), .ctrlOut(ctrlOut),
		.linkPhyAllow(linkPhyAllow), .packetAccept(packetAccept),
		.linkFlush(linkFlush)
	);

	// Compares one observed value against its expectation.
	task automatic chk(input string what, input logic [31:0] seen,
			input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// Prints the counts and the verdict, then ends the run.
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : final_report

	// One-cycle write strobe, launched and dropped on falling edges.
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(negedge clk);
		regWrite = 1'b1;
		regAddr = a;
		regWdata = d;
		@(negedge clk);
		regWrite = 1'b0;
	endtask : wr

	// The answer stands in the cycle after the strobe was taken.
	task automatic rd(input logic [11:0] a, output logic [31:0] d,
			output logic abt);
		@(negedge clk);
		regRead = 1'b1;
		regAddr = a;
		@(negedge clk);
		regRead = 1'b0;
		d = regRdata;
		abt = regAbort;
	endtask : rd

	// Pulses the packet inputs and gathers the reply pulses for a while.
	task automatic pulse(input logic t, input logic p, output logic [2:0] got);
		got = 3'b000;
		@(negedge clk);
		tardyRequest = t;
		linkPacketValid = p;
		@(negedge clk);
		tardyRequest = 1'b0;
		linkPacketValid = 1'b0;
		repeat (4) begin
			got = got | {tardyAck, tardyEvent, packetAccept};
			@(negedge clk);
		end
	endtask : pulse

	// Reset contents, reserved bits and a write to read-only places.
	task automatic t_reset_values;
		rd(`OFS_CTRL_SET, rv, ab);
		chk("reset value", rv, 32'h00800000);
		chk("reset outputs", ctrlOut, 8'h20);
		wr(`OFS_CTRL_SET, 32'h9F80FFFF & ~32'h00010000);
		rd(`OFS_CTRL_CLR, rv, ab);
		chk("read-only bits", rv, 32'h00800000);
		wr(`OFS_CTRL_CLR, 32'h00800000);
		rd(`OFS_CTRL_SET, rv, ab);
		chk("perm not clearable", rv, 32'h00800000);
		$display("test reset_values done");
	endtask : t_reset_values

	// Set and clear addresses, gating of extras and packets.
	task automatic t_set_clear;
		logic [2:0] got;
		wr(`OFS_CTRL_SET, 32'h604E0000);
		rd(`OFS_CTRL_SET, rv, ab);
		chk("set all", rv, 32'h60CE0000);
		chk("ctrl all on", ctrlOut, 8'hFE);
		chk("extras on", ctrlOut.phyExtrasOn, 1'b1);
		chk("swap", ctrlOut.swapBypass, 1'b1);
		chk("posting", ctrlOut.writePostingOn, 1'b1);
		chk("phy allow", linkPhyAllow, 1'b1);
		pulse(1'b1, 1'b1, got);
		chk("tardy, event, accept", got, 3'b111);
		wr(`OFS_CTRL_CLR, 32'h20000000);
		pulse(1'b1, 1'b0, got);
		chk("no tardy when off", got, 3'b000);
		wr(`OFS_CTRL_CLR, 32'h00020000);
		rd(`OFS_CTRL_CLR, rv, ab);
		chk("clear connect", rv, 32'h40CC0000);
		chk("extras gated", ctrlOut.phyExtrasOn, 1'b0);
		pulse(1'b0, 1'b1, got);
		chk("detached", got, 3'b000);
		wr(`OFS_CTRL_CLR, 32'h00080000);
		// The gate follows the stored bit one cycle later.
		@(negedge clk);
		chk("phy blocked", linkPhyAllow, 1'b0);
		$display("test set_clear done");
	endtask : t_set_clear

	// Software reset reads one while busy and restores the contents.
	task automatic t_soft_reset;
		int n;
		logic fl;
		logic st;
		wr(`OFS_CTRL_SET, 32'h604E0000);
		wr(`OFS_CTRL_SET, 32'h00010000);
		fl = 1'b0;
		st = 1'b0;
		n = 0;
		rd(`OFS_CTRL_SET, rv, ab);
		chk("busy bit", rv[16], 1'b1);
		while (rv[16] === 1'b1 && n < 20) begin
			fl = fl | linkFlush;
			st = st | ctrlOut.swResetTrigger;
			rd(`OFS_CTRL_SET, rv, ab);
			n++;
		end
		chk("flush seen", fl, 1'b1);
		chk("trigger out", st, 1'b1);
		chk("busy reads", n < 20, 1'b1);
		chk("after reset", rv, 32'h00800000);
		$display("test soft_reset done");
	endtask : t_soft_reset

	// Accesses to the PHY clock domain with that clock stopped.
	task automatic t_phy_domain;
		phyClkRunning = 1'b0;
		repeat (6) @(negedge clk);
		rd(`OFS_PHYDOM_LO0, rv, ab);
		chk("abort low range", ab, 1'b1);
		rd(`OFS_PHYDOM_HI1, rv, ab);
		chk("abort high range", ab, 1'b1);
		rd(12'h040, rv, ab);
		chk("unmapped no abort", ab, 1'b0);
		chk("unmapped data", rv, 32'h00000000);
		abortSuppress = 1'b1;
		rd(`OFS_PHYDOM_HI0, rv, ab);
		chk("all ones", rv, `ALL_ONES);
		chk("suppressed abort", ab, 1'b0);
		abortSuppress = 1'b0;
		phyClkRunning = 1'b1;
		repeat (6) @(negedge clk);
		rd(`OFS_PHYDOM_LO1, rv, ab);
		chk("clock back", ab, 1'b0);
		$display("test phy_domain done");
	endtask : t_phy_domain

	// The global reset pin alone clears the permission bit.
	task automatic t_global_reset;
		globalRstN = 1'b0;
		repeat (6) @(negedge clk);
		rd(`OFS_CTRL_SET, rv, ab);
		chk("perm cleared", rv[23], 1'b0);
		chk("perm out", ctrlOut.phyConfigPermission, 1'b0);
		globalRstN = 1'b1;
		$display("test global_reset done");
	endtask : t_global_reset

	// Cuts a hang short well after the tests should have finished.
	initial begin
		#(100 * 5000);
		failures++;
		final_report();
	end

	// Main sequence: ten cycles of reset, then strap settling, then tests.
	initial begin
		repeat (10) @(negedge clk);
		rst = 1'b0;
		repeat (8) @(negedge clk);
		t_reset_values();
		t_set_clear();
		t_soft_reset();
		t_phy_domain();
		t_global_reset();
		final_report();
	end
endmodule : link_host_control_tb
